// File: logic/dspdt_defines.vh
// Purpose: Constants shared by the DSP saturation and data transfer datapath
// Assumes: Included by bare name from the design files under logic/
// Notes:   Definitions only; no processes live here
`ifndef DSPDT_DEFINES_VH
`define DSPDT_DEFINES_VH

// Fixed-point saturation limits, full 40-bit accumulator pattern
`define DSPDT_FIX_MAX     40'h007fffffff
`define DSPDT_FIX_MIN     40'hff80000000
// Integer saturation limits, upper 24 bits only (low word is don't-care)
`define DSPDT_INT_MAX_HI  24'h007fff
`define DSPDT_INT_MIN_HI  24'hff8000

// Condition select codes for the DSP condition flag
`define DSPDT_CS_CARRY    3'h0
`define DSPDT_CS_NEG      3'h1
`define DSPDT_CS_ZERO     3'h2
`define DSPDT_CS_OVF      3'h3
`define DSPDT_CS_SGT      3'h4
`define DSPDT_CS_SGE      3'h5

// Register index for single transfers (and ALU destinations 0..7)
`define DSPDT_R_X0        4'h0
`define DSPDT_R_X1        4'h1
`define DSPDT_R_Y0        4'h2
`define DSPDT_R_Y1        4'h3
`define DSPDT_R_M0        4'h4
`define DSPDT_R_M1        4'h5
`define DSPDT_R_A0        4'h6
`define DSPDT_R_A1        4'h7
`define DSPDT_R_A0G       4'h8
`define DSPDT_R_A1G       4'h9

// Single transfer queue entry layout
`define DSPDT_SE_LOAD     37
`define DSPDT_SE_LONG     36
`define DSPDT_SE_REG_HI   35
`define DSPDT_SE_REG_LO   32
`define DSPDT_SE_WIDTH    38

// Queue depth and legacy multiply-accumulate saturation width
`define DSPDT_FIFO_DEPTH  16
`define DSPDT_FIFO_AW     4
`define DSPDT_MAC_SAT_W   48

`endif

// File: logic/dspdt_core.v
// Purpose: DSP saturating arithmetic, X/Y memory transfers and single transfers
// Assumes: All inputs synchronous to core_clk; memories answer within the cycle their request is on the bus
// Notes:   Single transfers queue in a FIFO and yield the general bus to instruction fetch
`timescale 1ns/1ns
`include "dspdt_defines.vh"

// Queue of single transfer requests, flip-flop storage
module dspdt_fifo #(
  parameter WIDTH = `DSPDT_SE_WIDTH,
  parameter DEPTH = `DSPDT_FIFO_DEPTH,
  parameter AW    = `DSPDT_FIFO_AW
) (
  input  wire             core_clk,
  input  wire             reset,
  input  wire             in_valid,
  output reg              in_ready_q,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words
  reg  [AW-1:0]    wr_ptr_q;         // Next slot to fill
  reg  [AW-1:0]    rd_ptr_q;         // Oldest slot
  reg  [AW:0]      cnt_q;            // Occupancy
  reg  [AW:0]      cnt_d;
  wire             push;
  wire             pop;

  assign push      = in_valid && in_ready_q;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_q];

  // Next occupancy
  always @*
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  // Pointers, count and registered ready; ready looks ahead so it is never late
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_ptr_q   <= {AW{1'b0}};
      rd_ptr_q   <= {AW{1'b0}};
      cnt_q      <= {(AW+1){1'b0}};
      in_ready_q <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      cnt_q      <= cnt_d;
      in_ready_q <= (cnt_d != DEPTH[AW:0]);
    end
  end

  // Data write, no reset needed on storage
  always @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end
endmodule

module dspdt_core #(
  parameter MAC_SAT_W = `DSPDT_MAC_SAT_W,
  parameter FIFO_DEPTH = `DSPDT_FIFO_DEPTH
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        sat_enable,        // Saturation bit of cpu_status_reg
  input  wire        op_valid,          // DSP data operation this cycle
  input  wire        op_long_instr,     // Set for a 32-bit parallel instruction
  input  wire        op_sub,            // Subtract instead of add
  input  wire        op_integer,        // Integer rather than fixed-point
  input  wire        op_cond,           // Conditional operation
  input  wire [2:0]  op_cs,             // Condition select
  input  wire [1:0]  op_sx,             // x0,x1,a0,a1
  input  wire [1:0]  op_sy,             // y0,y1,m0,m1
  input  wire [2:0]  op_dest,           // Register index 0..7
  input  wire        mac_valid,         // CPU multiply-accumulate step
  input  wire [63:0] mac_product,       // Signed product to accumulate
  input  wire        x_xfer,            // X memory transfer requested
  input  wire        x_load,            // Load (1) or store (0)
  input  wire        x_sel,             // Register 0 or 1 of the pair
  input  wire [15:0] x_addr,            // X pointer
  input  wire [15:0] x_rdata,           // X memory read data, next cycle
  input  wire        y_xfer,
  input  wire        y_load,
  input  wire        y_sel,
  input  wire [15:0] y_addr,
  input  wire [15:0] y_rdata,
  input  wire        st_valid,          // Single transfer request
  input  wire        st_load,
  input  wire        st_long,
  input  wire [3:0]  st_reg,
  input  wire [31:0] st_addr,
  input  wire        fetch_req,         // Instruction fetch wants general bus
  input  wire [31:0] gen_rdata,         // General bus read data, next cycle
  output wire        st_ready_q,        // Queue can take a request
  output reg         fetch_grant_q,
  output reg         gen_req_q,
  output reg         gen_we_q,
  output reg         gen_long_q,
  output reg  [31:0] general_addr_bus_q,
  output reg  [31:0] general_data_bus_q,
  output reg         x_req_q,
  output reg         x_we_q,
  output reg  [15:0] x_mem_addr_bus_q,
  output reg  [15:0] x_mem_data_bus_q,
  output reg         y_req_q,
  output reg         y_we_q,
  output reg  [15:0] y_mem_addr_bus_q,
  output reg  [15:0] y_mem_data_bus_q,
  output reg         stall_q,           // One stall cycle to the pipeline
  output reg         ovf_flag_q,
  output reg         dsp_condition_flag_q,
  output reg  [31:0] x_operand_reg0_q,
  output reg  [31:0] x_operand_reg1_q,
  output reg  [31:0] y_operand_reg0_q,
  output reg  [31:0] y_operand_reg1_q,
  output reg  [31:0] mult_reg0_q,
  output reg  [31:0] mult_reg1_q,
  output reg  [39:0] accumulator0_q,    // Guard byte in [39:32]
  output reg  [39:0] accumulator1_q,
  output reg  [31:0] mac_high_reg_q,
  output reg  [31:0] mac_low_reg_q
);
  // ALU operand selection and results
  reg  [39:0] sx;                       // Source X, sign-extended
  reg  [39:0] sy;                       // Source Y, sign-extended
  wire [40:0] sgn_sum;                  // Signed sum for true sign
  wire [40:0] uns_sum;                  // Unsigned sum for carry/borrow
  wire [39:0] raw_res;                  // Wrapped result
  wire        ovf;                      // Beyond 32-bit two's complement
  wire        vr;                       // Beyond 40-bit range
  reg  [39:0] sat_res;                  // Clamp value
  wire [39:0] alu_res;                  // Value written to the destination
  wire        op_exec;                  // Operation takes effect
  reg         dc_d;                     // Candidate condition flag
  reg         op_prev_q;                // Data operation one cycle ago
  // Multiply-accumulate
  wire [63:0] mac_acc;
  wire [63:0] mac_sum;
  wire        mac_ovf;
  wire [63:0] mac_max;
  wire [63:0] mac_min;
  // X/Y load returns
  reg         x_ld_pend_q;
  reg         x_ld_sel_q;
  reg         y_ld_pend_q;
  reg         y_ld_sel_q;
  // Single transfer path
  wire [`DSPDT_SE_WIDTH-1:0] q_out;
  wire        q_valid;
  wire        q_pop;
  wire [3:0]  q_reg;
  reg  [31:0] st_word;                  // Store data for the drained entry
  reg         g_ld_pend_q;
  reg         g_ld_long_q;
  reg  [3:0]  g_ld_reg_q;

  // Operand muxes, 32-bit registers sign-extended into guard positions
  always @*
  begin
    case (op_sx)
      2'h0:    sx = {{8{x_operand_reg0_q[31]}}, x_operand_reg0_q};
      2'h1:    sx = {{8{x_operand_reg1_q[31]}}, x_operand_reg1_q};
      2'h2:    sx = accumulator0_q;
      default: sx = accumulator1_q;
    endcase
    case (op_sy)
      2'h0:    sy = {{8{y_operand_reg0_q[31]}}, y_operand_reg0_q};
      2'h1:    sy = {{8{y_operand_reg1_q[31]}}, y_operand_reg1_q};
      2'h2:    sy = {{8{mult_reg0_q[31]}}, mult_reg0_q};
      default: sy = {{8{mult_reg1_q[31]}}, mult_reg1_q};
    endcase
  end

  assign sgn_sum = op_sub ? {sx[39], sx} - {sy[39], sy} : {sx[39], sx} + {sy[39], sy};
  assign uns_sum = op_sub ? {1'b0, sx} - {1'b0, sy} : {1'b0, sx} + {1'b0, sy};
  assign raw_res = sgn_sum[39:0];
  assign vr      = sgn_sum[40] ^ sgn_sum[39];
  // Guard bits are not part of the range: bits 39..31 must all agree
  assign ovf     = !((&raw_res[39:31]) || !(|raw_res[39:31]));
  assign op_exec = op_valid && (!op_cond || dsp_condition_flag_q);

  // Clamp value by sign of the full result and arithmetic kind
  always @*
  begin
    if (op_integer)
      sat_res = sgn_sum[40] ? {`DSPDT_INT_MIN_HI, raw_res[15:0]}
                            : {`DSPDT_INT_MAX_HI, raw_res[15:0]};
    else
      sat_res = sgn_sum[40] ? `DSPDT_FIX_MIN : `DSPDT_FIX_MAX;
  end

  // Saturation replaces the wrapped value only when enabled and overflowed
  assign alu_res = (sat_enable && ovf) ? sat_res : raw_res;

  // Condition flag candidate per select mode
  always @*
  begin
    case (op_cs)
      `DSPDT_CS_CARRY: dc_d = uns_sum[40];
      `DSPDT_CS_NEG:   dc_d = alu_res[39];
      `DSPDT_CS_ZERO:  dc_d = (alu_res == 40'h0000000000);
      `DSPDT_CS_OVF:   dc_d = ovf && !sat_enable;
      `DSPDT_CS_SGT:   dc_d = !((alu_res[39] ^ vr) || (alu_res == 40'h0000000000));
      `DSPDT_CS_SGE:   dc_d = !(alu_res[39] ^ vr);
      default:         dc_d = dsp_condition_flag_q;                // Reserved codes keep the flag
    endcase
  end

  // Multiply-accumulate keeps its own narrower legacy window
  assign mac_acc = {mac_high_reg_q, mac_low_reg_q};
  assign mac_sum = mac_acc + mac_product;
  assign mac_max = {{(65-MAC_SAT_W){1'b0}}, {(MAC_SAT_W-1){1'b1}}};
  assign mac_min = ~mac_max;
  assign mac_ovf = !((&mac_sum[63:MAC_SAT_W-1]) || !(|mac_sum[63:MAC_SAT_W-1]));

  // Flags; transfers never reach this, and conditional ops leave flags alone
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ovf_flag_q           <= 1'b0;
      dsp_condition_flag_q <= 1'b0;
      op_prev_q            <= 1'b0;
    end
    else
    begin
      op_prev_q <= op_valid;
      if (op_valid && !op_cond)
      begin
        ovf_flag_q           <= ovf && !sat_enable;
        dsp_condition_flag_q <= dc_d;
      end
    end
  end

  // Multiply-accumulate pair
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      mac_high_reg_q <= 32'h00000000;
      mac_low_reg_q  <= 32'h00000000;
    end
    else if (mac_valid)
    begin
      if (sat_enable && mac_ovf)
        {mac_high_reg_q, mac_low_reg_q} <= mac_sum[63] ? mac_min : mac_max;
      else
        {mac_high_reg_q, mac_low_reg_q} <= mac_sum;
    end
  end

  // X/Y buses: both may run in one cycle, independent of any condition
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      x_req_q          <= 1'b0;
      x_we_q           <= 1'b0;
      x_mem_addr_bus_q <= 16'h0000;
      x_mem_data_bus_q <= 16'h0000;
      y_req_q          <= 1'b0;
      y_we_q           <= 1'b0;
      y_mem_addr_bus_q <= 16'h0000;
      y_mem_data_bus_q <= 16'h0000;
      x_ld_pend_q      <= 1'b0;
      x_ld_sel_q       <= 1'b0;
      y_ld_pend_q      <= 1'b0;
      y_ld_sel_q       <= 1'b0;
    end
    else
    begin
      // Requests leave on dedicated buses only, so no other memory is reached
      x_req_q          <= x_xfer;
      x_we_q           <= x_xfer && !x_load;
      x_mem_addr_bus_q <= x_addr;
      x_mem_data_bus_q <= x_sel ? accumulator1_q[31:16] : accumulator0_q[31:16];
      y_req_q          <= y_xfer;
      y_we_q           <= y_xfer && !y_load;
      y_mem_addr_bus_q <= y_addr;
      y_mem_data_bus_q <= y_sel ? accumulator1_q[31:16] : accumulator0_q[31:16];
      x_ld_pend_q      <= x_xfer && x_load;                       // Alone or beside an op alike
      x_ld_sel_q       <= x_sel;
      y_ld_pend_q      <= y_xfer && y_load;
      y_ld_sel_q       <= y_sel;
    end
  end

  // Single transfer queue; requests enter only in cycles without op_valid
  dspdt_fifo #(
    .WIDTH (`DSPDT_SE_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (`DSPDT_FIFO_AW)
  ) u_queue (
    .core_clk   (core_clk),
    .reset      (reset),
    .in_valid   (st_valid && !op_valid),
    .in_ready_q (st_ready_q),
    .in_data    ({st_load, st_long, st_reg, st_addr}),
    .out_valid  (q_valid),
    .out_ready  (!fetch_req),
    .out_data   (q_out)
  );

  // Fetch wins the general bus; the queue waits and back-pressures
  assign q_pop = q_valid && !fetch_req;
  assign q_reg = q_out[`DSPDT_SE_REG_HI:`DSPDT_SE_REG_LO];

  // Store data: word takes the upper word, guard byte leaves zeros above
  always @*
  begin
    case (q_reg)
      `DSPDT_R_X0:  st_word = x_operand_reg0_q;
      `DSPDT_R_X1:  st_word = x_operand_reg1_q;
      `DSPDT_R_Y0:  st_word = y_operand_reg0_q;
      `DSPDT_R_Y1:  st_word = y_operand_reg1_q;
      `DSPDT_R_M0:  st_word = mult_reg0_q;
      `DSPDT_R_M1:  st_word = mult_reg1_q;
      `DSPDT_R_A0:  st_word = accumulator0_q[31:0];
      `DSPDT_R_A1:  st_word = accumulator1_q[31:0];
      `DSPDT_R_A0G: st_word = {24'h000000, accumulator0_q[39:32]};
      `DSPDT_R_A1G: st_word = {24'h000000, accumulator1_q[39:32]};
      default:      st_word = 32'h00000000;
    endcase
    if (!q_out[`DSPDT_SE_LONG] && (q_reg < `DSPDT_R_A0G))
      st_word = {16'h0000, st_word[31:16]};
  end

  // General bus drive, any 32-bit address; stall when a store trails an operation
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      fetch_grant_q      <= 1'b0;
      gen_req_q          <= 1'b0;
      gen_we_q           <= 1'b0;
      gen_long_q         <= 1'b0;
      general_addr_bus_q <= 32'h00000000;
      general_data_bus_q <= 32'h00000000;
      g_ld_pend_q        <= 1'b0;
      g_ld_long_q        <= 1'b0;
      g_ld_reg_q         <= 4'h0;
      stall_q            <= 1'b0;
    end
    else
    begin
      fetch_grant_q      <= fetch_req;
      gen_req_q          <= q_pop;
      gen_we_q           <= q_pop && !q_out[`DSPDT_SE_LOAD];
      gen_long_q         <= q_out[`DSPDT_SE_LONG];
      general_addr_bus_q <= q_out[31:0];
      general_data_bus_q <= st_word;
      g_ld_pend_q        <= q_pop && q_out[`DSPDT_SE_LOAD];
      g_ld_long_q        <= q_out[`DSPDT_SE_LONG];
      g_ld_reg_q         <= q_reg;
      stall_q            <= op_prev_q && ((x_xfer && !x_load) || (y_xfer && !y_load) ||
                                          (st_valid && !st_load));
    end
  end

  // Register file writes; clashing destinations resolve by fixed order only
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      x_operand_reg0_q <= 32'h00000000;
      x_operand_reg1_q <= 32'h00000000;
      y_operand_reg0_q <= 32'h00000000;
      y_operand_reg1_q <= 32'h00000000;
      mult_reg0_q      <= 32'h00000000;
      mult_reg1_q      <= 32'h00000000;
      accumulator0_q   <= 40'h0000000000;
      accumulator1_q   <= 40'h0000000000;
    end
    else
    begin
      // ALU result first; later writes override, result undefined by contract
      if (op_exec)
      begin
        case (op_dest)
          3'h0:    x_operand_reg0_q <= alu_res[31:0];
          3'h1:    x_operand_reg1_q <= alu_res[31:0];
          3'h2:    y_operand_reg0_q <= alu_res[31:0];
          3'h3:    y_operand_reg1_q <= alu_res[31:0];
          3'h4:    mult_reg0_q      <= alu_res[31:0];
          3'h5:    mult_reg1_q      <= alu_res[31:0];
          3'h6:    accumulator0_q   <= alu_res;
          default: accumulator1_q   <= alu_res;
        endcase
      end
      // Single load: word into upper, long whole; guards sign-extended
      if (g_ld_pend_q)
      begin
        case (g_ld_reg_q)
          `DSPDT_R_X0: x_operand_reg0_q <= g_ld_long_q ? gen_rdata : {gen_rdata[15:0], 16'h0000};
          `DSPDT_R_X1: x_operand_reg1_q <= g_ld_long_q ? gen_rdata : {gen_rdata[15:0], 16'h0000};
          `DSPDT_R_Y0: y_operand_reg0_q <= g_ld_long_q ? gen_rdata : {gen_rdata[15:0], 16'h0000};
          `DSPDT_R_Y1: y_operand_reg1_q <= g_ld_long_q ? gen_rdata : {gen_rdata[15:0], 16'h0000};
          `DSPDT_R_M0: mult_reg0_q      <= g_ld_long_q ? gen_rdata : {gen_rdata[15:0], 16'h0000};
          `DSPDT_R_M1: mult_reg1_q      <= g_ld_long_q ? gen_rdata : {gen_rdata[15:0], 16'h0000};
          `DSPDT_R_A0: accumulator0_q   <= g_ld_long_q ? {{8{gen_rdata[31]}}, gen_rdata}
                                                       : {{8{gen_rdata[15]}}, gen_rdata[15:0], 16'h0000};
          `DSPDT_R_A1: accumulator1_q   <= g_ld_long_q ? {{8{gen_rdata[31]}}, gen_rdata}
                                                       : {{8{gen_rdata[15]}}, gen_rdata[15:0], 16'h0000};
          `DSPDT_R_A0G: accumulator0_q[39:32] <= gen_rdata[7:0];
          `DSPDT_R_A1G: accumulator1_q[39:32] <= gen_rdata[7:0];
          default: ;
        endcase
      end
      // X/Y loads: upper word written, lower word cleared
      if (x_ld_pend_q)
      begin
        if (x_ld_sel_q)
          x_operand_reg1_q <= {x_rdata, 16'h0000};
        else
          x_operand_reg0_q <= {x_rdata, 16'h0000};
      end
      if (y_ld_pend_q)
      begin
        if (y_ld_sel_q)
          y_operand_reg1_q <= {y_rdata, 16'h0000};
        else
          y_operand_reg0_q <= {y_rdata, 16'h0000};
      end
    end
  end
endmodule

// File: tb/dspdt_mem_model.sv
// Purpose: X, Y and general memory stand-in for the datapath bench
// Assumes: Read data equals the requested address, answered within the request cycle
// Notes:   Data stands one more cycle, then shows the inverted last address
`timescale 1ns/1ns
module dspdt_mem_model (
  input  wire        core_clk,
  input  wire        x_req_q,
  input  wire        x_we_q,
  input  wire [15:0] x_mem_addr_bus_q,
  output wire [15:0] x_rdata,
  input  wire        y_req_q,
  input  wire        y_we_q,
  input  wire [15:0] y_mem_addr_bus_q,
  output wire [15:0] y_rdata,
  input  wire        gen_req_q,
  input  wire        gen_we_q,
  input  wire [31:0] general_addr_bus_q,
  output wire [31:0] gen_rdata
);
  reg        xh_q, yh_q, gh_q; // Read answered last cycle
  reg [15:0] xa_q, ya_q;       // Last addresses seen
  reg [31:0] ga_q;
  // Remember reads so the data stands into the next cycle
  always @(posedge core_clk)
  begin
    {xh_q, yh_q, gh_q} <= {x_req_q & ~x_we_q, y_req_q & ~y_we_q, gen_req_q & ~gen_we_q};
    {xa_q, ya_q, ga_q} <= {x_mem_addr_bus_q, y_mem_addr_bus_q, general_addr_bus_q};
  end
  // Outside a read the lines repeat old data for one cycle only, then invert, so stale sampling shows up
  assign x_rdata   = (x_req_q & ~x_we_q) ? x_mem_addr_bus_q : (xh_q ? xa_q : ~xa_q);
  assign y_rdata   = (y_req_q & ~y_we_q) ? y_mem_addr_bus_q : (yh_q ? ya_q : ~ya_q);
  assign gen_rdata = (gen_req_q & ~gen_we_q) ? general_addr_bus_q : (gh_q ? ga_q : ~ga_q);
endmodule

// File: tb/dspdt_core_properties.sv
// Purpose: Temporal checks on the datapath ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every dspdt_core instance
`timescale 1ns/1ns
module dspdt_core_properties (
  input wire        core_clk,
  input wire        reset,
  input wire        sat_enable,
  input wire        op_valid,
  input wire        op_cond,
  input wire [2:0]  op_cs,
  input wire [2:0]  op_dest,
  input wire        mac_valid,
  input wire        x_xfer,
  input wire        x_load,
  input wire        x_sel,
  input wire [15:0] x_addr,
  input wire [15:0] x_rdata,
  input wire        fetch_req,
  input wire        gen_req_q,
  input wire        x_req_q,
  input wire        x_we_q,
  input wire [15:0] x_mem_addr_bus_q,
  input wire [15:0] x_mem_data_bus_q,
  input wire        stall_q,
  input wire        ovf_flag_q,
  input wire        dsp_condition_flag_q,
  input wire [31:0] x_operand_reg0_q,
  input wire [39:0] accumulator0_q
);
  default clocking ck @(posedge core_clk); endclocking
  default disable iff (reset);
  a_sat_no_ovf: assert property (op_valid && sat_enable && !op_cond |=> !ovf_flag_q)
    else $error("overflow flag set under saturation");
  a_sat_no_cond: assert property (op_valid && sat_enable && !op_cond && op_cs == 3'h3 |=> !dsp_condition_flag_q)
    else $error("condition flag set in overflow mode under saturation");
  a_sat_in_range: assert property (op_valid && sat_enable && !op_cond && op_dest == 3'h6
    |=> accumulator0_q[39:31] == 9'h000 || accumulator0_q[39:31] == 9'h1ff)
    else $error("saturated result out of range");
  a_xfer_keeps_flags: assert property (!op_valid && !mac_valid |=> $stable(ovf_flag_q) && $stable(dsp_condition_flag_q))
    else $error("flags changed without an operation");
  a_x_addr_out: assert property (x_xfer |=> x_req_q && x_mem_addr_bus_q == $past(x_addr))
    else $error("x request or address wrong");
  a_x_store_word: assert property (x_xfer && !x_load && !x_sel |=> x_we_q && x_mem_data_bus_q == $past(accumulator0_q[31:16]))
    else $error("x store data wrong");
  a_x_load_word: assert property (x_xfer && x_load && !x_sel |=> ##2 x_operand_reg0_q == {$past(x_rdata), 16'h0000})
    else $error("x load result wrong");
  a_stall_after_op: assert property (op_valid ##1 (!op_valid && x_xfer && !x_load) |=> stall_q)
    else $error("missing stall");
  a_stall_cause: assert property (stall_q |-> $past(op_valid, 2))
    else $error("stall without preceding operation");
  a_gen_yields: assert property (gen_req_q |-> !$past(fetch_req))
    else $error("general bus taken while fetch pending");
endmodule
bind dspdt_core dspdt_core_properties dspdt_core_properties_i (.*);

// File: tb/dspdt_core_bench.sv
// Purpose: Self-checking bench for saturation and data transfers
// Assumes: Memory model answers with the address as data
// Notes:   Accumulate path tied off; transfers and arithmetic exercised
`timescale 1ns/1ns
module dspdt_core_bench;
  reg         core_clk, reset, sat_enable, op_valid, op_sub, op_integer, op_cond, rdy;
  reg         x_xfer, x_load, x_sel, y_xfer, y_load, y_sel, st_valid, st_load, st_long, fetch_req;
  reg  [2:0]  op_cs, op_dest;
  reg  [1:0]  op_sx, op_sy;
  reg  [3:0]  st_reg;
  reg  [15:0] x_addr, y_addr;
  reg  [31:0] st_addr;
  reg  [39:0] sv;
  wire        op_long_instr = 1'b0;
  wire        mac_valid = 1'b0;
  wire [63:0] mac_product = 64'h0;
  wire        st_ready_q, fetch_grant_q, gen_req_q, gen_we_q, gen_long_q, x_req_q, x_we_q;
  wire        y_req_q, y_we_q, stall_q, ovf_flag_q, dsp_condition_flag_q;
  wire [15:0] x_rdata, y_rdata, x_mem_addr_bus_q, x_mem_data_bus_q, y_mem_addr_bus_q, y_mem_data_bus_q;
  wire [31:0] gen_rdata, general_addr_bus_q, general_data_bus_q, x_operand_reg0_q, x_operand_reg1_q;
  wire [31:0] y_operand_reg0_q, y_operand_reg1_q, mult_reg0_q, mult_reg1_q, mac_high_reg_q, mac_low_reg_q;
  wire [39:0] accumulator0_q, accumulator1_q;
  integer     fails, total_checks, cycles, i, n;
  // Arithmetic cases {sub, integer, sat} and the accumulator each must give
  localparam [17:0]  MD = {3'h7, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0};
  localparam [239:0] EA = {40'hff80000000, 40'hff80000000, 40'hff00010000,
                           40'h007fff0000, 40'h007fffffff, 40'h00fffe0000};
  // Single transfers {load, long, reg, addr} and expected register or bus
  localparam [227:0] ST = {2'b00, 4'h8, 32'h300, 2'b01, 4'h6, 32'h200, 2'b00, 4'h7, 32'h100,
                           2'b10, 4'h8, 32'h5a, 2'b11, 4'h6, 32'h80001234, 2'b10, 4'h7, 32'h9abc};
  localparam [239:0] SE = {40'h5a, 40'h80001234, 40'h9abc, 40'h5a80001234, 40'hff80001234, 40'hff9abc0000};
  dspdt_core dspdt_core_i (.*);
  dspdt_mem_model dspdt_mem_model_i (.*);
  // 25 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard, well above the roughly 110 cycles the tests need
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      end_of_test;
    end
  end
  task chk(input [8*8:1] what, input [39:0] seen, input [39:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("Error %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task edges(input integer k);
  begin
    repeat (k) @(posedge core_clk);
    #1;
  end
  endtask
  // X and Y transfer together, optionally beside a conditional operation
  task xy(input c, input ld, input [15:0] xa, input [15:0] ya);
  begin
    @(posedge core_clk);
    {x_xfer, y_xfer, x_load, y_load, op_valid, op_cond, x_addr, y_addr} <= {2'b11, ld, ld, c, c, xa, ya};
    @(posedge core_clk);
    {x_xfer, y_xfer, op_valid, op_cond} <= 4'h0;
    #1;
    chk("xaddr", {x_req_q, x_mem_addr_bus_q}, {1'b1, xa});
    chk("yaddr", {y_req_q, y_we_q, y_mem_addr_bus_q}, {1'b1, ~ld, ya});
  end
  endtask
  // Store right after an operation, or one instruction later
  task stall_try(input gap, input ex);
  begin
    @(posedge core_clk);
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    if (gap) @(posedge core_clk);
    {x_xfer, x_load, y_xfer, y_load} <= 4'ha;
    @(posedge core_clk);
    {x_xfer, y_xfer} <= 2'b00;
    #1;
    chk("xystore", {x_we_q, x_mem_data_bus_q, y_we_q, y_mem_data_bus_q}, {1'b1, 16'hffff, 1'b1, 16'hffff});
    chk("stall", stall_q, ex);
    edges(1);
    chk("stall1", stall_q, 1'b0);
  end
  endtask
  task end_of_test;
  begin
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  initial
  begin
    {fails, total_checks, cycles} = 96'h0;
    {reset, sat_enable, op_valid, op_sub, op_integer, op_cond, x_xfer, x_load, x_sel} = 9'h100;
    {y_xfer, y_load, y_sel, st_valid, st_load, st_long, fetch_req, rdy} = 8'h00;
    {op_cs, op_dest, op_sx, op_sy, st_reg, x_addr, y_addr, st_addr} = {3'h3, 3'h6, 8'h0, 64'h0};
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    edges(1);
    chk("ready", {st_ready_q, gen_req_q, stall_q}, 3'h4);
    xy(1'b1, 1'b1, 16'h7fff, 16'h7fff);
    edges(1);
    chk("x0y0", {x_operand_reg0_q, y_operand_reg0_q[31:24]}, {32'h7fff0000, 8'h7f});
    for (i = 0; i < 6; i = i + 1)
    begin
      if (i == 3) xy(1'b0, 1'b1, 16'h8000, 16'h7fff);
      if (i == 3) edges(1);
      @(posedge core_clk);
      {op_valid, op_sub, op_integer, sat_enable} <= {1'b1, MD[3*i +: 3]};
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1;
      chk("acc0", accumulator0_q, EA[40*i +: 40]);
      chk("flags", {ovf_flag_q, dsp_condition_flag_q}, {2{~MD[3*i]}});
    end
    {op_sub, op_integer} <= 2'b00;
    stall_try(1'b0, 1'b1);
    stall_try(1'b1, 1'b0);
    for (i = 0; i < 6; i = i + 1)
    begin
      @(posedge core_clk);
      {st_valid, st_load, st_long, st_reg, st_addr} <= {1'b1, ST[38*i +: 38]};
      @(posedge core_clk);
      st_valid <= 1'b0;
      edges(1);
      chk("genaddr", {gen_long_q, gen_we_q, general_addr_bus_q}, {st_long, ~st_load, st_addr});
      if (st_load) edges(2);
      sv = st_load ? (st_reg == 4'h7 ? accumulator1_q : accumulator0_q) : {8'h0, general_data_bus_q
           & (st_long ? 32'hffffffff : (st_reg[3] ? 32'hff : 32'hffff))};
      chk("single", sv, SE[40*i +: 40]);
    end
    {n, st_load, st_reg} = 37'h0;
    for (i = 0; i < 20; i = i + 1)
    begin
      @(posedge core_clk);
      n = n + (st_valid & rdy);
      {st_valid, fetch_req} <= {(i < 19), 1'b1};
      #1;
      rdy = st_ready_q;
    end
    chk("queued", n, 16);
    chk("grant", {fetch_grant_q, gen_req_q}, 2'b10);
    n = 0;
    for (i = 0; i < 30; i = i + 1)
    begin
      @(posedge core_clk);
      fetch_req <= 1'b0;
      #1;
      n = n + gen_req_q;
    end
    chk("drained", n, 16);
    end_of_test;
  end
endmodule
